// >>> shared/xmb_pkg.sv
// Package for the external memory bus interface: register map, fields, reset values and types.
package xmb_pkg;

    // Register byte addresses on APB.
    localparam logic [11:0] XMB_CONFIG_OFS = 12'h000;
    localparam logic [11:0] XMB_TIMING_OFS = 12'h004;
    localparam logic [11:0] XMB_PAGE_OFS   = 12'h008;
    localparam logic [11:0] XMB_STATUS_OFS = 12'h00C;

    // Configuration register fields.
    localparam int XMB_CFG_MUXSEL_BIT = 4;
    localparam int XMB_CFG_MODE_LSB   = 2;
    localparam int XMB_CFG_ALE_LSB    = 0;

    // Timing register fields.
    localparam int XMB_TC_SETUP_LSB  = 6;
    localparam int XMB_TC_STROBE_LSB = 2;
    localparam int XMB_TC_HOLD_LSB   = 0;

    // Reset values: setup and hold at their maximum.
    localparam logic [4:0] XMB_CONFIG_RST = 5'h03;
    localparam logic [7:0] XMB_TIMING_RST = 8'hFF;
    localparam logic [7:0] XMB_PAGE_RST   = 8'h00;

    // On-chip RAM is 4 kB, so twelve address bits.
    localparam int          XMB_ONCHIP_AW  = 12;
    localparam int          XMB_ONCHIP_WDS = 4096;
    localparam logic [3:0]  XMB_ZERO4      = 4'h0;

    // Fixed overhead of an off-chip access.
    localparam logic [5:0] XMB_FIXED_CYC = 6'h04;

    // Memory mode codes.
    typedef enum logic [1:0] {
        XMB_MODE_INT   = 2'b00,
        XMB_MODE_SPLIT = 2'b01,
        XMB_MODE_BANK  = 2'b10,
        XMB_MODE_EXT   = 2'b11
    } xmb_mode_type;

    // Access phases, Gray coded along the usual path.
    typedef enum logic [2:0] {
        XMB_ST_IDLE  = 3'b000,
        XMB_ST_ALEH  = 3'b001,
        XMB_ST_ALEL  = 3'b011,
        XMB_ST_SETUP = 3'b010,
        XMB_ST_STRB  = 3'b110,
        XMB_ST_HOLD  = 3'b111,
        XMB_ST_TAIL  = 3'b101,
        XMB_ST_DONE  = 3'b100
    } xmb_state_type;

    // Core-side request of one external move.
    typedef struct packed {
        logic        wide;
        logic        write;
        logic [15:0] data_pointer_reg;
        logic [7:0]  index;
        logic [7:0]  wdata;
    } xmb_req_type;

    // External pin bundle; enables are active low.
    typedef struct packed {
        logic [7:0] addr_hi;
        logic       addr_hi_oe_n;
        logic [7:0] addr_lo;
        logic       addr_lo_oe_n;
        logic [7:0] data_out;
        logic       data_oe_n;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
    } xmb_pins_type;

endpackage : xmb_pkg

// >>> logic/xmb_top.sv
// External memory bus interface: APB registers, address resolution, on-chip RAM and strobe sequencer.
`timescale 1ns/1ns
module xmb_top
    import xmb_pkg::*;
(
    input  wire logic         pclk,          // System clock, 50 MHz.
    input  wire logic         presetn,       // Asynchronous reset, active low.
    input  wire logic         psel,          // APB select.
    input  wire logic         penable,       // APB access phase.
    input  wire logic         pwrite,        // APB direction.
    input  wire logic [11:0]  paddr,         // APB byte address.
    input  wire logic [31:0]  pwdata,        // APB write data.
    output logic              pready,        // APB ready.
    output logic [31:0]       prdata,        // APB read data.
    output logic              pslverr,       // APB error on unmapped address.
    input  wire logic         req_valid,     // Core requests an external move.
    input  wire xmb_req_type  req,           // Request contents.
    output logic              req_ready,     // Block idle, request taken.
    output logic              rsp_valid,     // One-cycle pulse: access finished.
    output logic [7:0]        rsp_rdata,     // Read data of finished access.
    output logic              rsp_offchip,   // Finished access went off-chip.
    input  wire logic [7:0]   pin_data_in,   // Data pins (shared pins when multiplexed).
    output xmb_pins_type      pins           // External memory pins.
);

    // Software registers.
    logic [4:0]  memif_config_reg;
    logic [7:0]  memif_timing_reg;
    logic [7:0]  extended_data_ram_page_reg;

    // Access sequencer state.
    xmb_state_type state_reg;
    logic [3:0]    cnt_reg;
    logic          wide_reg;
    logic          write_reg;
    logic          offchip_reg;
    logic          mux_reg;
    logic          hi_drive_reg;
    logic [15:0]   addr_reg;
    logic [7:0]    wdata_reg;
    logic [7:0]    rdata_reg;
    logic [5:0]    cycles_reg;
    logic [5:0]    last_cycles_reg;
    logic [7:0]    din_meta_reg;
    logic [7:0]    din_sync_reg;
    logic [7:0]    ram_mem [XMB_ONCHIP_WDS];

    // Decoded fields.
    logic         mux_select_bit;
    xmb_mode_type memory_mode_field;
    logic [1:0]   latch_strobe_width_field;
    logic [1:0]   addr_setup_field;
    logic [1:0]   addr_hold_field;
    logic [3:0]   strobe_width_field;
    logic [3:0]   ale_cycles;
    logic [15:0]  eff_addr;
    logic         go_off;
    logic         hi_drive;
    logic         apb_wr;
    logic         mapped;
    logic         setup_none;
    logic         hold_none;

    assign mux_select_bit           = memif_config_reg[XMB_CFG_MUXSEL_BIT];
    assign memory_mode_field        = xmb_mode_type'(memif_config_reg[XMB_CFG_MODE_LSB +: 2]);
    assign latch_strobe_width_field = memif_config_reg[XMB_CFG_ALE_LSB +: 2];
    assign addr_setup_field         = memif_timing_reg[XMB_TC_SETUP_LSB +: 2];
    assign strobe_width_field       = memif_timing_reg[XMB_TC_STROBE_LSB +: 4];
    assign addr_hold_field          = memif_timing_reg[XMB_TC_HOLD_LSB +: 2];

    // Latch strobe high and low time in cycles; codes 00 and 01 both mean one.
    always_comb begin
        case (latch_strobe_width_field)
            2'b10:   ale_cycles = 4'h3;
            2'b11:   ale_cycles = 4'h4;
            default: ale_cycles = 4'h1;
        endcase
    end

    // Effective address: 8-bit moves use page and index, 16-bit the data pointer.
    assign eff_addr = req.wide ? req.data_pointer_reg : {extended_data_ram_page_reg, req.index};

    // Steering; for 8-bit moves the page byte is the upper address and so decides.
    always_comb begin
        case (memory_mode_field)
            XMB_MODE_INT:   go_off = 1'b0;
            XMB_MODE_EXT:   go_off = 1'b1;
            default:        go_off = (eff_addr[15:XMB_ONCHIP_AW] != XMB_ZERO4);
        endcase
    end

    // Upper pins are driven for 16-bit moves, and for 8-bit moves only in bank mode.
    assign hi_drive = req.wide || (memory_mode_field == XMB_MODE_BANK);

    // A zero setup or hold skips its state, so a non-multiplexed access lasts exactly setup plus strobe plus hold plus five cycles.
    assign setup_none = (addr_setup_field == 2'b00);
    assign hold_none  = (addr_hold_field == 2'b00);

    // APB slave: zero wait states, unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign mapped = (paddr == XMB_CONFIG_OFS) || (paddr == XMB_TIMING_OFS) ||
                    (paddr == XMB_PAGE_OFS) || (paddr == XMB_STATUS_OFS);
    assign apb_wr = psel && penable && pwrite;
    assign pslverr = psel && penable && !mapped;

    // Register writes; a change mid-access would retime the strobes, so it waits for idle in software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memif_config_reg <= XMB_CONFIG_RST;
            memif_timing_reg <= XMB_TIMING_RST;
            extended_data_ram_page_reg    <= XMB_PAGE_RST;
        end else if (apb_wr) begin
            if (paddr == XMB_CONFIG_OFS) memif_config_reg <= pwdata[4:0];
            if (paddr == XMB_TIMING_OFS) memif_timing_reg <= pwdata[7:0];
            if (paddr == XMB_PAGE_OFS)   extended_data_ram_page_reg    <= pwdata[7:0];
        end
    end

    // Read mux; status shows busy, last target and last access length.
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                XMB_CONFIG_OFS: prdata = {27'h000_0000, memif_config_reg};
                XMB_TIMING_OFS: prdata = {24'h00_0000, memif_timing_reg};
                XMB_PAGE_OFS:   prdata = {24'h00_0000, extended_data_ram_page_reg};
                XMB_STATUS_OFS: prdata = {16'h0000, 2'b00, last_cycles_reg, 6'h00, offchip_reg,
                                          (state_reg != XMB_ST_IDLE)};
                default:        prdata = 32'h0000_0000;
            endcase
        end
    end

    // Requests are taken only while idle; the core holds its request until then.
    assign req_ready = (state_reg == XMB_ST_IDLE);

    // Data pins come from outside the clock domain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_meta_reg <= 8'h00;
            din_sync_reg <= 8'h00;
        end else begin
            din_meta_reg <= pin_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // On-chip RAM, 4 kB; upper address bits are dropped, so addresses alias every 4 kB.
    always_ff @(posedge pclk) begin
        if (req_valid && req_ready && !go_off && req.write) begin
            ram_mem[eff_addr[XMB_ONCHIP_AW-1:0]] <= req.wdata;
        end
    end

    // Sequencer. Off-chip: latch high, latch low, setup, strobe, hold, then four fixed cycles.
    // An on-chip access completes in a single DONE cycle with no strobes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= XMB_ST_IDLE;
            cnt_reg      <= 4'h0;
            wide_reg     <= 1'b0;
            write_reg    <= 1'b0;
            offchip_reg  <= 1'b0;
            mux_reg      <= 1'b0;
            hi_drive_reg <= 1'b0;
            addr_reg     <= 16'h0000;
            wdata_reg    <= 8'h00;
            rdata_reg    <= 8'h00;
            cycles_reg   <= 6'h00;
        end else begin
            case (state_reg)
                XMB_ST_IDLE: begin
                    if (req_valid) begin
                        wide_reg     <= req.wide;
                        write_reg    <= req.write;
                        offchip_reg  <= go_off;
                        mux_reg      <= !mux_select_bit;
                        hi_drive_reg <= hi_drive;
                        addr_reg     <= eff_addr;
                        wdata_reg    <= req.wdata;
                        cycles_reg   <= 6'h01;
                        if (!go_off) begin
                            rdata_reg <= ram_mem[eff_addr[XMB_ONCHIP_AW-1:0]];
                            state_reg <= XMB_ST_DONE;
                        end else if (!mux_select_bit) begin
                            cnt_reg   <= ale_cycles - 4'h1;
                            state_reg <= XMB_ST_ALEH;
                        end else if (!setup_none) begin
                            cnt_reg   <= {2'b00, addr_setup_field} - 4'h1;
                            state_reg <= XMB_ST_SETUP;
                        end else begin
                            cnt_reg   <= strobe_width_field;
                            state_reg <= XMB_ST_STRB;
                        end
                    end
                end
                XMB_ST_ALEH: begin
                    // Latch open: the shared pins carry the low address byte.
                    cycles_reg <= cycles_reg + 6'h01;
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= ale_cycles - 4'h1;
                        state_reg <= XMB_ST_ALEL;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                XMB_ST_ALEL: begin
                    // Latch closed; the setup count starts when this phase ends.
                    cycles_reg <= cycles_reg + 6'h01;
                    if (cnt_reg == 4'h0) begin
                        if (!setup_none) begin
                            cnt_reg   <= {2'b00, addr_setup_field} - 4'h1;
                            state_reg <= XMB_ST_SETUP;
                        end else begin
                            cnt_reg   <= strobe_width_field;
                            state_reg <= XMB_ST_STRB;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                XMB_ST_SETUP: begin
                    // Entered only for a nonzero setup, which then takes exactly that many cycles.
                    cycles_reg <= cycles_reg + 6'h01;
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= strobe_width_field;
                        state_reg <= XMB_ST_STRB;
                    end else begin
                        cnt_reg    <= cnt_reg - 4'h1;
                    end
                end
                XMB_ST_STRB: begin
                    cycles_reg <= cycles_reg + 6'h01;
                    if (cnt_reg == 4'h0) begin
                        // Pins reach din_sync_reg two cycles late, so reads need a strobe of three or more.
                        if (!write_reg) begin
                            rdata_reg <= din_sync_reg;
                        end
                        if (!hold_none) begin
                            cnt_reg   <= {2'b00, addr_hold_field} - 4'h1;
                            state_reg <= XMB_ST_HOLD;
                        end else begin
                            cnt_reg   <= XMB_FIXED_CYC[3:0] - 4'h2;
                            state_reg <= XMB_ST_TAIL;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                XMB_ST_HOLD: begin
                    // Address and write data stay driven after the strobe rises.
                    cycles_reg <= cycles_reg + 6'h01;
                    if (cnt_reg == 4'h0) begin
                        cnt_reg   <= XMB_FIXED_CYC[3:0] - 4'h2;
                        state_reg <= XMB_ST_TAIL;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                XMB_ST_TAIL: begin
                    // Three of the four fixed cycles; DONE is the fourth.
                    cycles_reg <= cycles_reg + 6'h01;
                    if (cnt_reg == 4'h0) begin
                        state_reg <= XMB_ST_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                XMB_ST_DONE: begin
                    // The response cycle is also the last of the fixed cycles.
                    state_reg <= XMB_ST_IDLE;
                end
                default: begin
                    state_reg <= XMB_ST_IDLE;
                end
            endcase
        end
    end

    // Length of the last finished access, for software to check the timing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cycles_reg <= 6'h00;
        end else if (state_reg == XMB_ST_DONE) begin
            last_cycles_reg <= cycles_reg;
        end
    end

    // Response pulse; read data and target can change as soon as the next access is taken.
    assign rsp_valid   = (state_reg == XMB_ST_DONE);
    assign rsp_rdata   = rdata_reg;
    assign rsp_offchip = offchip_reg;

    // Pin drive. Off-chip states only; on-chip accesses leave every strobe idle.
    logic active;
    logic in_ale;
    assign active = offchip_reg && (state_reg != XMB_ST_IDLE) && (state_reg != XMB_ST_DONE);
    assign in_ale = (state_reg == XMB_ST_ALEH) || (state_reg == XMB_ST_ALEL);

    always_comb begin
        pins.addr_hi      = addr_reg[15:8];
        pins.addr_hi_oe_n = !(active && hi_drive_reg);
        pins.addr_lo      = addr_reg[7:0];
        pins.addr_lo_oe_n = !(active && !mux_reg);
        pins.ale          = active && mux_reg && (state_reg == XMB_ST_ALEH);
        pins.rd_n         = !(active && !write_reg && (state_reg == XMB_ST_STRB));
        pins.wr_n         = !(active && write_reg && (state_reg == XMB_ST_STRB));
        if (mux_reg) begin
            // Shared pins: low address during latch phases, then write data.
            pins.data_out  = in_ale ? addr_reg[7:0] : wdata_reg;
            pins.data_oe_n = !(active && (in_ale || write_reg));
        end else begin
            pins.data_out  = wdata_reg;
            pins.data_oe_n = !(active && write_reg);
        end
    end

endmodule : xmb_top

// >>> tb/xmb_assertions.sv
// Checker of pin and handshake timing of the external memory bus interface.
`timescale 1ns/1ns
module xmb_assertions
    import xmb_pkg::*;
(
    input wire logic         pclk,        // System clock.
    input wire logic         presetn,     // Reset, active low.
    input wire logic         req_valid,   // Core request.
    input wire logic         req_ready,   // Block idle.
    input wire logic         rsp_valid,   // Access finished.
    input wire logic         rsp_offchip, // Finished access was off-chip.
    input wire xmb_pins_type pins         // External memory pins.
);
    logic [4:0] strb_cnt; // Cycles the current strobe has been low.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Counting beats unrolling a sixteen-deep repetition, which tools handle badly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) strb_cnt <= 5'h00;
        else if (!pins.rd_n || !pins.wr_n) strb_cnt <= strb_cnt + 5'h01;
        else strb_cnt <= 5'h00;
    end
    // Latch strobe phase, data strobes and the handshake.
    property p_ale_addr; pins.ale |-> !pins.data_oe_n && pins.addr_lo_oe_n && pins.rd_n && pins.wr_n; endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("latch strobe high without address out");
    property p_ale_hold; pins.ale && $past(pins.ale) |-> $stable(pins.data_out); endproperty
    a_ale_hold: assert property (p_ale_hold) else $error("address moved while latch open");
    property p_ale_low; $fell(pins.ale) |-> pins.rd_n && pins.wr_n; endproperty
    a_ale_low: assert property (p_ale_low) else $error("strobe right at latch close");
    property p_ale_max; pins.ale [*4] |=> !pins.ale; endproperty
    a_ale_max: assert property (p_ale_max) else $error("latch strobe over four cycles");
    property p_wr_data; !pins.wr_n |-> !pins.data_oe_n && pins.rd_n; endproperty
    a_wr_data: assert property (p_wr_data) else $error("write strobe without data driven");
    property p_rd_free; !pins.rd_n |-> pins.data_oe_n; endproperty
    a_rd_free: assert property (p_rd_free) else $error("data driven during read");
    property p_strb_max; (!pins.rd_n || !pins.wr_n) |-> strb_cnt < 5'h10; endproperty
    a_strb_max: assert property (p_strb_max) else $error("strobe over sixteen cycles");
    property p_rsp_idle; rsp_valid |=> !rsp_valid && req_ready; endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("no idle after response");
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("taken request did not start");
    property p_onchip; rsp_valid && !rsp_offchip |-> $past(req_ready); endproperty
    a_onchip: assert property (p_onchip) else $error("on-chip access took extra cycles");
    property p_off_min; rsp_valid && rsp_offchip |-> !$past(req_ready) && !$past(req_ready, 4); endproperty
    a_off_min: assert property (p_off_min) else $error("off-chip access under five cycles");
endmodule : xmb_assertions

// >>> tb/xmb_mem_model.sv
// Behavioural external RAM with a transparent address latch on the memory pins.
`timescale 1ns/1ns
module xmb_mem_model
    import xmb_pkg::*;
#(
    parameter logic [7:0] PORT_HI = 8'hA5 // Upper address the port latches hold.
)
(
    input wire logic         pclk,        // System clock.
    input wire xmb_pins_type pins,        // Pins from the interface.
    output logic [7:0]       pin_data_in  // Data lines back to the interface.
);
    logic [7:0]  mem [0:65535];  // Storage.
    logic [7:0]  latch_q;        // External latch output.
    logic [7:0]  last_q = 8'h00; // Last value on the data lines.
    logic [15:0] addr;           // Address the RAM sees.
    // Follows while the strobe is high, frozen once it falls.
    always_latch begin
        if (pins.ale) latch_q <= pins.data_out;
    end
    // Undriven upper pins fall back to the port latches; shared pins give the low byte via the latch.
    assign addr = {pins.addr_hi_oe_n ? PORT_HI : pins.addr_hi, pins.addr_lo_oe_n ? latch_q : pins.addr_lo};
    // Lines that nobody drives show the inverse of the last value, so stale data never matches.
    always @(posedge pclk) begin
        if (!pins.wr_n) mem[addr] <= pins.data_oe_n ? ~last_q : pins.data_out;
        last_q <= pin_data_in;
    end
    // The RAM drives only while read is strobed and the device has let go.
    assign pin_data_in = (!pins.rd_n && pins.data_oe_n) ? mem[addr] : ~last_q;
endmodule : xmb_mem_model

// >>> tb/xmb_top_tb.sv
// Self-checking bench of the external memory bus interface with an external RAM model.
`timescale 1ns/1ns
module xmb_top_tb
    import xmb_pkg::*;
;
    localparam logic [7:0] PORT_HI = 8'hA5; // Port latch level on undriven upper pins.
    typedef struct packed { logic off; logic rd; logic [31:0] data; logic [31:0] cyc; } xmb_exp_type;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic         req_valid, req_ready, rsp_valid, rsp_offchip;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, seed, cnt, n, s, w, h, al, ticks;
    logic [7:0]   rsp_rdata, pin_data_in, d;
    xmb_req_type  req;
    xmb_pins_type pins;
    xmb_exp_type  e;
    xmb_exp_type  exp_q [$];
    int           fail_count, samples_checked;
    // Cases: mode, wide, page, pointer or index, off-chip, address seen at the pins.
    logic [1:0]  tm [8] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    logic        tw [8] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1};
    logic [7:0]  tp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h60, 8'h00};
    logic [15:0] ta [8] = '{16'h0123, 16'h0045, 16'h5010, 16'h0010, 16'h0011, 16'h0011, 16'h0022, 16'h8001};
    logic        to [8] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
    logic [15:0] te [8] = '{16'h0123, 16'hA545, 16'h5010, 16'h0010, 16'hA511, 16'h0011, 16'h6022, 16'h8001};

    xmb_top u_xmb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_offchip(rsp_offchip), .pin_data_in(pin_data_in), .pins(pins));
    xmb_mem_model #(.PORT_HI(PORT_HI)) u_xmb_mem_model (.pclk(pclk), .pins(pins), .pin_data_in(pin_data_in));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
        samples_checked++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : cmp
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r,
                       output logic x);
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = prdata;
        x = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask : apb
    task automatic chk(input logic [11:0] a, input logic [31:0] want);
        logic [31:0] r;
        logic        x;
        apb(1'h0, a, 32'h0000_0000, r, x);
        cmp(r, want, "register");
    endtask : chk
    // One external move; the expectation is queued first and the task waits until it is consumed.
    task automatic xfer(input logic wide, input logic wr, input logic [15:0] dp, input logic [7:0] wd,
                        input logic off, input logic [31:0] cyc, input logic [7:0] want);
        exp_q.push_back('{off, !wr, {24'h0, want}, cyc});
        @(posedge pclk);
        req_valid <= 1'h1; req <= '{wide, wr, dp, dp[7:0], wd};
        @(posedge pclk);
        while (req_ready !== 1'h1) @(posedge pclk);
        req_valid <= 1'h0;
        while (exp_q.size() != 0) @(posedge pclk);
    endtask : xfer

    // Clock at 50 MHz.
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // Monitor: cycle count since the taking edge, compared with the oldest note at each response.
    always @(posedge pclk) begin
        if (rsp_valid === 1'h1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("unexpected at %0t: response with nothing pending", $time);
            end else begin
                e = exp_q.pop_front();
                cmp({31'h0, rsp_offchip}, {31'h0, e.off}, "off-chip flag");
                cmp(cnt, e.cyc, "access cycles");
                if (e.rd) cmp({24'h0, rsp_rdata}, e.data, "read data");
            end
        end
        cnt = (req_valid === 1'h1 && req_ready === 1'h1) ? 32'h1 : cnt + 32'h1;
    end
    // A hang is cut short well beyond the longest expected run.
    always @(posedge pclk) begin
        ticks++;
        if (ticks == 32'h0000_9C40) begin
            fail_count++;
            end_sim();
        end
    end
    // Main sequence.
    initial begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0;
        req_valid = 1'h0; req = '0; seed = 32'h3979_55ad; cnt = 32'h0; ticks = 32'h0;
        fail_count = 0; samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        chk(XMB_CONFIG_OFS, 32'h0000_0003);
        chk(XMB_TIMING_OFS, 32'h0000_00FF);
        chk(XMB_PAGE_OFS, 32'h0000_0000);
        apb(1'h0, 12'h010, 32'h0000_0000, rd, err);
        cmp({31'h0, err}, 32'h1, "unmapped error");
        // Internal only: aliasing and page plus index addressing.
        apb(1'h1, XMB_CONFIG_OFS, 32'h0000_0013, rd, err);
        xfer(1'h1, 1'h1, 16'h1005, 8'h5A, 1'h0, 32'h1, 8'h00);
        xfer(1'h1, 1'h0, 16'h2005, 8'h00, 1'h0, 32'h1, 8'h5A);
        apb(1'h1, XMB_PAGE_OFS, 32'h0000_0030, rd, err);
        xfer(1'h0, 1'h0, 16'h0005, 8'h00, 1'h0, 32'h1, 8'h5A);
        // Every mode case on both bus kinds, all latch codes, random timing.
        for (int mx = 0; mx < 2; mx++) begin
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                s = {30'h0, seed[1:0]};
                w = {28'h0, seed[5:2] | 4'h2};
                h = {30'h0, seed[7:6]};
                al = i % 4;
                d = seed[15:8];
                apb(1'h1, XMB_CONFIG_OFS, {27'h0, mx[0], tm[i], al[1:0]}, rd, err);
                apb(1'h1, XMB_TIMING_OFS, {24'h0, s[1:0], w[3:0], h[1:0]}, rd, err);
                apb(1'h1, XMB_PAGE_OFS, {24'h0, tp[i]}, rd, err);
                n = (al == 32'h2) ? 32'h3 : (al == 32'h3) ? 32'h4 : 32'h1;
                n = to[i] ? s + w + h + 32'h5 + ((mx == 0) ? 32'h2 * n : 32'h0) : 32'h1;
                xfer(tw[i], 1'h1, ta[i], d, to[i], n, 8'h00);
                if (to[i]) cmp({24'h0, u_xmb_mem_model.mem[te[i]]}, {24'h0, d}, "pin address");
                xfer(tw[i], 1'h0, ta[i], ~d, to[i], n, d);
            end
        end
        chk(XMB_TIMING_OFS, {24'h0, s[1:0], w[3:0], h[1:0]});
        chk(XMB_STATUS_OFS, {18'h0, n[5:0], 6'h00, 1'h1, 1'h0});
        end_sim();
    end
endmodule : xmb_top_tb

bind xmb_top xmb_assertions u_xmb_assertions (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_offchip(rsp_offchip), .pins(pins));
